// >>> design/dpl_pkg.sv
// dual probe position latch: constants, types and object map
//
// Notes on behaviour
// - control word low byte configures channel 1, high byte channel 2.
// - a channel works only while its enable bit (0 or 8) is one.
// - trigger-mode bit 1/9 zero latches first trigger only, one latches every trigger.
// - source bit 2/10 zero picks the external latch input, one the internal pulse.
// - rising edges capture only while bit 4/12 is one.
// - falling edges capture only while bit 5/13 is one.
// - status word low byte reports channel 1, high byte channel 2.
// - status bit 0/8 shows whether the channel is enabled.
// - status bit 1/9 is set once a rising-edge capture happened.
// - status bit 2/10 is set once a falling-edge capture happened.
// - internal selector zero picks Z-phase output, one picks timing pulse.
// - with the external trigger, capture source zero is feedback, one is command.
// - Z-phase trigger captures feedback, timing pulse captures command position.
// - selection settings exist per axis, axis number 1 to 4 in sub-index.
// - rising and falling captures sit in separate read-only signed 32-bit registers.
// - timing pulse output gives one pulse per 7.2 degrees of shaft rotation.
package dpl_pkg;

  localparam int NUM_AXES = 4;
  localparam int NUM_CH   = 2;
  localparam int AX_W     = 2;
  localparam int CH_BITS  = 8;
  localparam int POS_W    = 32;

  // object indices
  localparam logic [15:0] IDX_CAPSRC1   = 16'h44b0;
  localparam logic [15:0] IDX_CAPSRC2   = 16'h44b1;
  localparam logic [15:0] IDX_INTSEL1   = 16'h44b2;
  localparam logic [15:0] IDX_INTSEL2   = 16'h44b3;
  localparam logic [15:0] IDX_CTRL      = 16'h60b8;
  localparam logic [15:0] IDX_STATUS    = 16'h60b9;
  localparam logic [15:0] IDX_POS1_RISE = 16'h60ba;
  localparam logic [15:0] IDX_POS1_FALL = 16'h60bb;
  localparam logic [15:0] IDX_POS2_RISE = 16'h60bc;
  localparam logic [15:0] IDX_POS2_FALL = 16'h60bd;
  localparam logic [7:0]  AXIS_FIRST    = 8'h01;
  localparam logic [7:0]  AXIS_LAST     = 8'h04;

  // per-channel control and status bit positions
  localparam int CTL_ENABLE = 0;
  localparam int CTL_CONT   = 1;
  localparam int CTL_SRC    = 2;
  localparam int CTL_RISE   = 4;
  localparam int CTL_FALL   = 5;
  localparam int ST_ENABLED = 0;
  localparam int ST_RISE    = 1;
  localparam int ST_FALL    = 2;
  localparam logic [7:0]  CTL_USED_MASK = 8'h37;

  // values after reset
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0]  SEL_RESET  = 8'h00;

  // timing pulse: one period per 7.2 degrees at the default resolution
  localparam int STEPS_PER_REV  = 10000;
  localparam int TIM_DEG_X10    = 72;
  localparam int TURN_DEG_X10   = 3600;
  localparam int STEPS_PER_TIM  = STEPS_PER_REV * TIM_DEG_X10 / TURN_DEG_X10;
  localparam int TIM_RES_W      = 8;

  typedef logic signed [POS_W-1:0] dpl_pos_type;

  function automatic logic dpl_axis_ok(input logic [7:0] sub);
    return (sub >= AXIS_FIRST) && (sub <= AXIS_LAST);
  endfunction

  function automatic logic [AX_W-1:0] dpl_axis_of(input logic [7:0] sub);
    logic [7:0] idx;
    idx = sub - AXIS_FIRST;
    return idx[AX_W-1:0];
  endfunction

endpackage

// >>> design/dpl_chan_if.sv
// dual probe position latch: signals between the object block and one channel
`timescale 1ns/1ps
interface dpl_chan_if;
  import dpl_pkg::*;
  logic [CH_BITS-1:0] ctrl;
  logic               cap_src;
  logic               int_sel;
  logic               ext_in;
  logic               zsg_in;
  logic               tim_in;
  dpl_pos_type        fb_pos;
  dpl_pos_type        cmd_pos;
  logic [CH_BITS-1:0] status;
  dpl_pos_type        pos_rise;
  dpl_pos_type        pos_fall;

  modport owner (output ctrl, cap_src, int_sel, ext_in, zsg_in, tim_in, fb_pos, cmd_pos,
                 input status, pos_rise, pos_fall);
  modport chan  (input ctrl, cap_src, int_sel, ext_in, zsg_in, tim_in, fb_pos, cmd_pos,
                 output status, pos_rise, pos_fall);
endinterface

// >>> design/dpl_probe_chan.sv
// dual probe position latch: one probe channel, trigger edges and captures
`timescale 1ns/1ps
module dpl_probe_chan
  import dpl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // owner side
  dpl_chan_if.chan ch
);
  logic        ext_meta_q, ext_sync_q, zsg_meta_q, zsg_sync_q;
  logic        trig, trig_q, rise_edge, fall_edge, take_rise, take_fall;
  logic        en, cont, src, rise_en, fall_en, rise_flag_q, fall_flag_q;
  dpl_pos_type sel_pos, pos_rise_q, pos_fall_q;

  assign en      = ch.ctrl[CTL_ENABLE];
  assign cont    = ch.ctrl[CTL_CONT];
  assign src     = ch.ctrl[CTL_SRC];
  assign rise_en = ch.ctrl[CTL_RISE];
  assign fall_en = ch.ctrl[CTL_FALL];

  ////////////////////////////////////////////////////////////////////////////////
  // pins come from outside the clock domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      zsg_meta_q <= 1'b0;
      zsg_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= ch.ext_in;
      ext_sync_q <= ext_meta_q;
      zsg_meta_q <= ch.zsg_in;
      zsg_sync_q <= zsg_meta_q;
    end
  end

  assign trig = src ? (ch.int_sel ? ch.tim_in : zsg_sync_q) : ext_sync_q;
  assign sel_pos = src ? (ch.int_sel ? ch.cmd_pos : ch.fb_pos)
                       : (ch.cap_src ? ch.cmd_pos : ch.fb_pos);

  // trigger history runs while disabled, so enabling with an unchanged source never fakes an edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) trig_q <= 1'b0;
    else       trig_q <= trig;
  end

  assign rise_edge = trig & ~trig_q;
  assign fall_edge = ~trig & trig_q;
  assign take_rise = en && rise_en && rise_edge && (cont || !rise_flag_q);
  assign take_fall = en && fall_en && fall_edge && (cont || !fall_flag_q);

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rise_flag_q <= 1'b0;
      fall_flag_q <= 1'b0;
    end else if (!en) begin
      rise_flag_q <= 1'b0;
      fall_flag_q <= 1'b0;
    end else begin
      if (take_rise) rise_flag_q <= 1'b1;
      if (take_fall) fall_flag_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_rise_q <= '0;
      pos_fall_q <= '0;
    end else begin
      if (take_rise) pos_rise_q <= sel_pos;
      if (take_fall) pos_fall_q <= sel_pos;
    end
  end

  always_comb begin
    ch.status             = '0;
    ch.status[ST_ENABLED] = en;
    ch.status[ST_RISE]    = rise_flag_q;
    ch.status[ST_FALL]    = fall_flag_q;
  end
  assign ch.pos_rise = pos_rise_q;
  assign ch.pos_fall = pos_fall_q;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rise_take;
    en && rise_en && rise_edge && (cont || !rise_flag_q);
  endsequence

  a_rise_capture: assert property (
    s_rise_take |=> rise_flag_q && (pos_rise_q == $past(sel_pos)))
    else $error("rising capture did not land");
  a_rise_needs_enable: assert property (
    $changed(pos_rise_q) |-> $past(en && rise_en && rise_edge))
    else $error("rising capture without enable");
  a_fall_needs_enable: assert property (
    $changed(pos_fall_q) |-> $past(en && fall_en && fall_edge))
    else $error("falling capture without enable");
  a_single_shot_hold: assert property (
    en && !cont && rise_flag_q |=> $stable(pos_rise_q))
    else $error("first-trigger mode captured twice");
  a_zsg_takes_feedback: assert property (
    s_rise_take ##0 (src && !ch.int_sel) |=> pos_rise_q == $past(ch.fb_pos))
    else $error("z-phase capture not feedback");
  a_disable_clears: assert property (
    !en |=> !rise_flag_q && !fall_flag_q)
    else $error("flags survive disable");

endmodule // dpl_probe_chan

// >>> design/dpl_probe_latch.sv
// dual probe position latch: object access, per-axis settings, timing pulse, channels
`timescale 1ns/1ps
module dpl_probe_latch
  import dpl_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // object access port
  input  wire logic [15:0]              obj_index,
  input  wire logic [7:0]               obj_sub,
  input  wire logic                     obj_wr,
  input  wire logic                     obj_rd,
  input  wire logic [31:0]              obj_wdata,
  output logic      [31:0]              obj_rdata,
  output logic                          obj_ack,
  output logic                          obj_err,
  // per-axis positions from the motion core
  input  wire logic [NUM_AXES-1:0][31:0] feedback_pos,
  input  wire logic [NUM_AXES-1:0][31:0] command_pos,
  // per-axis trigger pins
  input  wire logic [NUM_AXES-1:0]      probe1_external_latch_in,
  input  wire logic [NUM_AXES-1:0]      probe2_external_latch_in,
  input  wire logic [NUM_AXES-1:0]      zphase_sync_out,
  // per-axis timing pulse
  output logic      [NUM_AXES-1:0]      timing_pulse_out
);
  import dpl_pkg::*;

  localparam logic [TIM_RES_W-1:0] TIM_MOD  = TIM_RES_W'(STEPS_PER_TIM);
  localparam logic [TIM_RES_W-1:0] TIM_HALF = TIM_RES_W'(STEPS_PER_TIM / 2);

  logic [15:0]          ctrl_q   [NUM_AXES];
  logic [7:0]           capsrc_q [NUM_AXES][NUM_CH];
  logic [7:0]           intsel_q [NUM_AXES][NUM_CH];
  logic [CH_BITS-1:0]   ch_status[NUM_AXES][NUM_CH];
  dpl_pos_type          ch_rise  [NUM_AXES][NUM_CH];
  dpl_pos_type          ch_fall  [NUM_AXES][NUM_CH];

  logic [NUM_AXES-1:0]  tim_seed_q;
  dpl_pos_type          tim_prev_q [NUM_AXES];
  logic [TIM_RES_W-1:0] tim_res_q  [NUM_AXES];
  logic [TIM_RES_W-1:0] tim_res_d  [NUM_AXES];
  logic [NUM_AXES-1:0]  tim_q;

  logic [AX_W-1:0]      axis;
  logic                 axis_ok, known, read_only, bad, wr_ok;
  logic [31:0]          rd_d;
  logic [31:0]          rdata_q;
  logic                 ack_q, err_q;

  // keeps the residue in 0..STEPS_PER_TIM-1; assumes under one period of motion per cycle
  function automatic logic [TIM_RES_W-1:0] tim_wrap(input logic [TIM_RES_W-1:0] res,
                                                    input dpl_pos_type delta);
    dpl_pos_type sum;
    sum = $signed({{(POS_W-TIM_RES_W){1'b0}}, res}) + delta;
    if (sum >= STEPS_PER_TIM) sum = sum - STEPS_PER_TIM;
    else if (sum < 0)         sum = sum + STEPS_PER_TIM;
    return sum[TIM_RES_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // object decode
  always_comb begin
    axis      = dpl_axis_of(obj_sub);
    axis_ok   = dpl_axis_ok(obj_sub);
    known     = 1'b1;
    read_only = 1'b0;
    rd_d      = '0;
    case (obj_index)
      IDX_CAPSRC1:   rd_d = {24'h000000, capsrc_q[axis][0]};
      IDX_CAPSRC2:   rd_d = {24'h000000, capsrc_q[axis][1]};
      IDX_INTSEL1:   rd_d = {24'h000000, intsel_q[axis][0]};
      IDX_INTSEL2:   rd_d = {24'h000000, intsel_q[axis][1]};
      IDX_CTRL:      rd_d = {16'h0000, ctrl_q[axis]};
      IDX_STATUS: begin
        rd_d      = {16'h0000, ch_status[axis][1], ch_status[axis][0]};
        read_only = 1'b1;
      end
      IDX_POS1_RISE: begin
        rd_d      = ch_rise[axis][0];
        read_only = 1'b1;
      end
      IDX_POS1_FALL: begin
        rd_d      = ch_fall[axis][0];
        read_only = 1'b1;
      end
      IDX_POS2_RISE: begin
        rd_d      = ch_rise[axis][1];
        read_only = 1'b1;
      end
      IDX_POS2_FALL: begin
        rd_d      = ch_fall[axis][1];
        read_only = 1'b1;
      end
      default: known = 1'b0;
    endcase
    bad   = !axis_ok || !known || (obj_wr && read_only);
    wr_ok = obj_wr && !bad;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // settings; reserved control bits are stored as zero whatever the host sends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int a = 0; a < NUM_AXES; a++) ctrl_q[a] <= CTRL_RESET;
    end else if (wr_ok && obj_index == IDX_CTRL) begin
      ctrl_q[axis] <= obj_wdata[15:0] & {CTL_USED_MASK, CTL_USED_MASK};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        for (int c = 0; c < NUM_CH; c++) begin
          capsrc_q[a][c] <= SEL_RESET;
          intsel_q[a][c] <= SEL_RESET;
        end
      end
    end else if (wr_ok) begin
      case (obj_index)
        IDX_CAPSRC1: capsrc_q[axis][0] <= obj_wdata[7:0];
        IDX_CAPSRC2: capsrc_q[axis][1] <= obj_wdata[7:0];
        IDX_INTSEL1: intsel_q[axis][0] <= obj_wdata[7:0];
        IDX_INTSEL2: intsel_q[axis][1] <= obj_wdata[7:0];
        default: ;
      endcase
    end
  end

  // one answer cycle after every access; bad accesses read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q   <= obj_rd || obj_wr;
      err_q   <= (obj_rd || obj_wr) && bad;
      rdata_q <= (obj_rd && !bad) ? rd_d : 32'h00000000;
    end
  end

  assign obj_ack   = ack_q;
  assign obj_err   = err_q;
  assign obj_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // timing pulse per axis: square wave, one period per STEPS_PER_TIM command steps
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_tim
    assign tim_res_d[a] = tim_wrap(tim_res_q[a], $signed(command_pos[a]) - tim_prev_q[a]);

    // first cycle after reset only seeds the previous position
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        tim_seed_q[a] <= 1'b0;
        tim_prev_q[a] <= '0;
        tim_res_q[a]  <= '0;
        tim_q[a]      <= 1'b0;
      end else begin
        tim_seed_q[a] <= 1'b1;
        tim_prev_q[a] <= $signed(command_pos[a]);
        if (tim_seed_q[a]) begin
          tim_res_q[a] <= tim_res_d[a];
          tim_q[a]     <= (tim_res_d[a] < TIM_HALF);
        end
      end
    end
  end

  assign timing_pulse_out = tim_q;

  ////////////////////////////////////////////////////////////////////////////////
  // eight channels, two per axis
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      dpl_chan_if ch_if ();

      assign ch_if.ctrl    = ctrl_q[a][c*CH_BITS +: CH_BITS];
      assign ch_if.cap_src = capsrc_q[a][c][0];
      assign ch_if.int_sel = intsel_q[a][c][0];
      assign ch_if.ext_in  = (c == 0) ? probe1_external_latch_in[a]
                                      : probe2_external_latch_in[a];
      assign ch_if.zsg_in  = zphase_sync_out[a];
      assign ch_if.tim_in  = tim_q[a];
      assign ch_if.fb_pos  = $signed(feedback_pos[a]);
      assign ch_if.cmd_pos = $signed(command_pos[a]);
      assign ch_status[a][c] = ch_if.status;
      assign ch_rise[a][c]   = ch_if.pos_rise;
      assign ch_fall[a][c]   = ch_if.pos_fall;

      dpl_probe_chan u_chan (
        .clk  (clk),
        .rstn (rstn),
        .ch   (ch_if.chan)
      );
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_ctrl_write_ax1;
    obj_wr && obj_index == IDX_CTRL && obj_sub == AXIS_FIRST;
  endsequence

  a_ctrl_write_split: assert property (
    s_ctrl_write_ax1 |=> ctrl_q[0] == ($past(obj_wdata[15:0]) & 16'h3737)
                         && obj_ack && !obj_err)
    else $error("control word write did not land");
  a_axis_range_err: assert property (
    (obj_rd || obj_wr) && (obj_sub == 8'h00 || obj_sub > AXIS_LAST) |=> obj_ack && obj_err)
    else $error("bad axis number accepted");
  a_status_halves: assert property (
    obj_rd && obj_index == IDX_STATUS && obj_sub == AXIS_FIRST
      |=> obj_rdata[7:0] == $past(ch_status[0][0]) && obj_rdata[15:8] == $past(ch_status[0][1]))
    else $error("status halves misplaced");
  a_status_enable_bit: assert property (
    obj_rd && obj_index == IDX_STATUS && obj_sub == AXIS_FIRST
      |=> obj_rdata[8] == $past(ctrl_q[0][8]) && obj_rdata[0] == $past(ctrl_q[0][0]))
    else $error("status enable bit wrong");
  a_status_read_only: assert property (
    obj_wr && obj_index == IDX_STATUS |=> obj_err)
    else $error("write to read-only object accepted");
  a_tim_half_wave: assert property (
    tim_seed_q[0] && $past(tim_seed_q[0]) |-> tim_q[0] == (tim_res_q[0] < TIM_HALF))
    else $error("timing pulse out of phase");
  a_tim_res_range: assert property (
    tim_res_q[0] < TIM_MOD)
    else $error("timing residue out of range");

endmodule // dpl_probe_latch

// >>> tb/dpl_host_model.sv
// host controller model: object read and write cycles towards the probe latch
`timescale 1ns/1ps
module dpl_host_model
  import dpl_pkg::*;
(
  // clock
  clk,
  // object access port
  obj_index,
  obj_sub,
  obj_wr,
  obj_rd,
  obj_wdata,
  obj_rdata,
  obj_ack,
  obj_err
);
  input  wire logic        clk;
  output logic      [15:0] obj_index;
  output logic      [7:0]  obj_sub;
  output logic             obj_wr;
  output logic             obj_rd;
  output logic      [31:0] obj_wdata;
  input  wire logic [31:0] obj_rdata;
  input  wire logic        obj_ack;
  input  wire logic        obj_err;

  initial begin
    obj_index = 16'h0000;
    obj_sub   = 8'h00;
    obj_wr    = 1'b0;
    obj_rd    = 1'b0;
    obj_wdata = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one strobe cycle per object; the answer is taken one edge after the taking edge
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, output logic [31:0] rdata,
                        output logic ack, output logic err);
    logic [31:0] wmask;
    wmask = (idx == IDX_CTRL) ? {16'h0000, CTL_USED_MASK, CTL_USED_MASK} : 32'hffff_ffff;
    @(posedge clk);
    obj_index <= idx;
    obj_sub   <= sub;
    obj_wr    <= wr;
    obj_rd    <= !wr;
    obj_wdata <= wd & wmask;
    @(posedge clk);
    obj_wr    <= 1'b0;
    obj_rd    <= 1'b0;
    @(posedge clk);
    rdata = obj_rdata;
    ack   = obj_ack;
    err   = obj_err;
    // released lines must not keep looking like the last access
    obj_index <= ~idx;
    obj_sub   <= ~sub;
    obj_wdata <= ~(wd & wmask);
  endtask
endmodule // dpl_host_model

// >>> tb/dual_probe_position_latch_tb.sv
// testbench for the dual probe position latch, axis 3 exercised, others watched
`timescale 1ns/1ps
module dual_probe_position_latch_tb;
  import dpl_pkg::*;
  logic                      clk;
  logic                      rstn;
  logic [15:0]               obj_index;
  logic [7:0]                obj_sub;
  logic                      obj_wr;
  logic                      obj_rd;
  logic [31:0]               obj_wdata;
  logic [31:0]               obj_rdata;
  logic                      obj_ack;
  logic                      obj_err;
  logic [NUM_AXES-1:0][31:0] feedback_pos;
  logic [NUM_AXES-1:0][31:0] command_pos;
  logic [NUM_AXES-1:0]       probe1_external_latch_in;
  logic [NUM_AXES-1:0]       probe2_external_latch_in;
  logic [NUM_AXES-1:0]       zphase_sync_out;
  logic [NUM_AXES-1:0]       timing_pulse_out;
  int                        err_total;
  int                        tests_run;
  localparam logic [15:0] IDX_TAB [6] = '{IDX_CAPSRC1, IDX_CAPSRC2, IDX_INTSEL1,
                                          IDX_INTSEL2, IDX_CTRL, IDX_STATUS};

  dpl_probe_latch u_dpl_probe_latch (.clk(clk), .rstn(rstn), .obj_index(obj_index),
    .obj_sub(obj_sub), .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata),
    .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
    .feedback_pos(feedback_pos), .command_pos(command_pos),
    .probe1_external_latch_in(probe1_external_latch_in),
    .probe2_external_latch_in(probe2_external_latch_in),
    .zphase_sync_out(zphase_sync_out), .timing_pulse_out(timing_pulse_out));

  dpl_host_model u_dpl_host_model (.clk(clk), .obj_index(obj_index), .obj_sub(obj_sub),
    .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
    .obj_ack(obj_ack), .obj_err(obj_err));

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // every access is answered with ack; writes and refusals return zero data
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic e_err, input logic [31:0] e_rd);
    logic [31:0] rv;
    logic        ack;
    logic        er;
    u_dpl_host_model.access(wr, idx, sub, wd, rv, ack, er);
    chk({30'h0, ack, er}, {30'h0, 1'b1, e_err});
    chk(rv, e_rd);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
    acc(1'b1, idx, sub, wd, 1'b0, 32'h0);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
    acc(1'b0, idx, sub, 32'h0, 1'b0, e);
  endtask

  // pins of axis 3; the wait covers two sync stages plus the edge register
  task automatic pin(input int which, input logic v);
    @(posedge clk);
    case (which)
      0: probe1_external_latch_in[2] <= v;
      1: probe2_external_latch_in[2] <= v;
      default: zphase_sync_out[2] <= v;
    endcase
    repeat (5) @(posedge clk);
  endtask

  task automatic pos(input logic [31:0] fb, input logic [31:0] cm);
    @(posedge clk);
    feedback_pos[2] <= fb;
    command_pos[2]  <= cm;
    repeat (5) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    err_total = 0;
    tests_run = 0;
    feedback_pos = '0;
    command_pos = '0;
    probe1_external_latch_in = '0;
    probe2_external_latch_in = '0;
    zphase_sync_out = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 1; a <= 4; a++) begin
      for (int i = 0; i < 6; i++) rd(IDX_TAB[i], 8'(a), 32'h0);
      wr(IDX_CAPSRC2, 8'(a), 32'(8'ha0 + a));
    end
    for (int a = 1; a <= 4; a++) rd(IDX_CAPSRC2, 8'(a), 32'(8'ha0 + a));
    for (int a = 1; a <= 4; a++) wr(IDX_CAPSRC2, 8'(a), 32'h0);
    wr(IDX_CTRL, 8'h01, 32'h0000_3737);
    rd(IDX_CTRL, 8'h01, 32'h0000_3737);
    rd(IDX_STATUS, 8'h01, 32'h0000_0101);
    wr(IDX_CTRL, 8'h01, 32'h0);
    acc(1'b0, IDX_CTRL, 8'h00, 32'h0, 1'b1, 32'h0);
    acc(1'b1, IDX_CTRL, 8'h05, 32'h11, 1'b1, 32'h0);
    acc(1'b0, 16'h6000, 8'h01, 32'h0, 1'b1, 32'h0);
    acc(1'b1, IDX_STATUS, 8'h03, 32'hffff, 1'b1, 32'h0);
    acc(1'b1, IDX_POS1_RISE, 8'h03, 32'h5, 1'b1, 32'h0);
    // channel 1, external pin, first trigger, rising only, feedback
    pos(32'h8000_0005, 32'h0);
    wr(IDX_CTRL, 8'h03, 32'h0000_0011);
    rd(IDX_STATUS, 8'h03, 32'h0000_0001);
    pin(0, 1'b1);
    rd(IDX_STATUS, 8'h03, 32'h0000_0003);
    rd(IDX_POS1_RISE, 8'h03, 32'h8000_0005);
    rd(IDX_STATUS, 8'h01, 32'h0);
    pos(32'h0000_1234, 32'h0);
    pin(0, 1'b0);
    rd(IDX_STATUS, 8'h03, 32'h0000_0003);
    pin(0, 1'b1);
    rd(IDX_POS1_RISE, 8'h03, 32'h8000_0005);
    rd(IDX_POS1_FALL, 8'h03, 32'h0);
    // disabling clears flags, keeps positions, and blocks edges
    wr(IDX_CTRL, 8'h03, 32'h0);
    rd(IDX_STATUS, 8'h03, 32'h0);
    rd(IDX_POS1_RISE, 8'h03, 32'h8000_0005);
    pin(0, 1'b0);
    pin(0, 1'b1);
    wr(IDX_CTRL, 8'h03, 32'h0000_0011);
    rd(IDX_STATUS, 8'h03, 32'h0000_0001);
    // channel 2, external pin, continuous, both edges, command position
    wr(IDX_CAPSRC2, 8'h03, 32'h1);
    wr(IDX_CTRL, 8'h03, 32'h0000_3311);
    pos(32'h0000_0777, 32'h0000_0040);
    pin(1, 1'b1);
    pos(32'h0000_0777, 32'h0000_0060);
    pin(1, 1'b0);
    pos(32'h0000_0777, 32'h0000_0070);
    pin(1, 1'b1);
    rd(IDX_STATUS, 8'h03, 32'h0000_0701);
    rd(IDX_POS2_RISE, 8'h03, 32'h0000_0070);
    rd(IDX_POS2_FALL, 8'h03, 32'h0000_0060);
    // channel 1 on Z-phase: feedback in spite of the command setting
    wr(IDX_CAPSRC1, 8'h03, 32'h1);
    wr(IDX_CTRL, 8'h03, 32'h0);
    wr(IDX_CTRL, 8'h03, 32'h0000_3315);
    pos(32'h0000_0abc, 32'h0000_0070);
    pin(2, 1'b1);
    rd(IDX_STATUS, 8'h03, 32'h0000_0103);
    rd(IDX_POS1_RISE, 8'h03, 32'h0000_0abc);
    // both channels on the timing pulse, first trigger: command position at the first period start, checked to hold at the second on channel 2 only
    wr(IDX_CTRL, 8'h03, 32'h0);
    wr(IDX_INTSEL1, 8'h03, 32'h1);
    wr(IDX_INTSEL2, 8'h03, 32'h1);
    wr(IDX_CTRL, 8'h03, 32'h0000_1515);
    chk({31'h0, timing_pulse_out[2]}, 32'h0);
    pos(32'h0000_0abc, 32'(STEPS_PER_TIM));
    chk({31'h0, timing_pulse_out[2]}, 32'h1);
    rd(IDX_STATUS, 8'h03, 32'h0000_0303);
    rd(IDX_POS2_RISE, 8'h03, 32'(STEPS_PER_TIM));
    rd(IDX_POS1_RISE, 8'h03, 32'(STEPS_PER_TIM));
    pos(32'h0000_0abc, 32'(STEPS_PER_TIM * 3 / 2));
    chk({31'h0, timing_pulse_out[2]}, 32'h0);
    pos(32'h0000_0abc, 32'(STEPS_PER_TIM * 2));
    chk({31'h0, timing_pulse_out[2]}, 32'h1);
    rd(IDX_POS2_RISE, 8'h03, 32'(STEPS_PER_TIM));
    rd(IDX_POS1_RISE, 8'h01, 32'h0);
    report_and_stop();
  end
endmodule // dual_probe_position_latch_tb
